// File: hw/io_map_pkg.sv
package io_map_pkg;

    // Input function selector codes
    typedef enum logic [4:0] {
        IN_OFF, IN_STOP, IN_FAULT_ON_HIGH, IN_FAULT_ON_LOW, IN_FAULT_CLEAR,
        IN_ISOLATOR_MONITOR, IN_LINE_CONTACTOR_CONFIRM, IN_BYPASS_CONFIRM,
        IN_OVERLOAD_CONTENT_CLEAR, IN_SOURCE_SELECT, IN_HEAT_INHIBIT, IN_HEAT_PERMIT,
        IN_SECOND_RAMP_SELECT, IN_SLOW_FWD, IN_SLOW_REV, IN_BRAKE_INHIBIT, IN_BRAKE_PERMIT,
        IN_RUN_PERMIT, IN_RUN_INHIBIT
    } in_func_t;

    // Relay function selector codes
    typedef enum logic [4:0] {
        RL_OFF, RL_FAULT_FAILSAFE, RL_FAULT_NONFAILSAFE, RL_RUNNING, RL_AT_SPEED, RL_ALARM,
        RL_READY, RL_LOCKED_OUT, RL_OVERCURRENT, RL_UNDERCURRENT, RL_OL_ALARM,
        RL_SHUNT_FAILSAFE, RL_SHUNT_NONFAILSAFE, RL_GROUND_FAULT, RL_ENERGY_SAVER,
        RL_HEATING, RL_SLOW_SPEED, RL_SLOW_FWD, RL_SLOW_REV, RL_FAN, RL_BRAKING
    } relay_func_t;

    // Starter state flags shown on relays
    typedef struct packed {
        logic faulted;
        logic running;
        logic at_speed;
        logic alarm;
        logic ready;
        logic locked_out;
        logic overcurrent;
        logic undercurrent;
        logic ol_alarm;
        logic shunt_trip;
        logic ground_fault;
        logic energy_saver;
        logic heating;
        logic slow_speed;
        logic slow_fwd;
        logic slow_rev;
        logic fan;
        logic braking;
    } starter_state_t;

    // Function requests derived from the logic inputs
    typedef struct packed {
        logic stop;
        logic fault_clear;
        logic isolator_ok;
        logic line_contactor_ok;
        logic bypass_ok;
        logic overload_clear;
        logic remote_source;
        logic heat_inhibit;
        logic heat_permit;
        logic second_ramp;
        logic slow_fwd;
        logic slow_rev;
        logic brake_inhibit;
        logic brake_permit;
        logic run_allow;
    } input_req_t;

    localparam int NUM_IN = 3;
    localparam int NUM_RELAY = 3;
    localparam int CLK_HZ = 25_000_000;
    // Delay setting is in tenths of a second
    localparam int DELAY_UNIT_MS = 100;
    localparam int TENTH_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam logic [9:0] DELAY_MIN = 10'h001;
    localparam logic [9:0] DELAY_MAX = 10'h384;
    localparam logic [9:0] DELAY_RST = 10'h001;
    localparam in_func_t IN0_RST = IN_STOP;
    localparam in_func_t IN12_RST = IN_OFF;
    localparam relay_func_t RL0_RST = RL_FAULT_FAILSAFE;
    localparam relay_func_t RL12_RST = RL_OFF;

endpackage

// File: hw/starter_io_function_mapper.sv
// Overview of operation
// - Three logic inputs, each with its own function selector.
// - Selector off means the input has no effect; default for inputs two, three.
// - Stop function is the three-wire stop command; default for input one.
// - fault_on_high trips when asserted, fault_on_low trips when deasserted.
// - Trip only after fault level held for fault_input_delay, 0.1 to 90.0 s.
// - The trip delay applies only to the two fault functions.
// - fault_clear_input resets the starter fault while asserted.
// - overload_content_clear resets overload content when asserted after overload trip.
// - source_select picks local when low, remote when high.
// - Heater inhibit or permit disables or enables heating while asserted.
// - second_ramp_select enables second acceleration ramp while asserted.
// - Slow-speed forward or reverse inputs select that slow-speed mode.
// - Brake inhibit or permit disables or enables DC injection braking.
// - run_permit high runs, low stops; run_inhibit is the reverse.
// - Inputs may monitor isolator, line contactor and bypass feedback.
// - Three relays; defaults fault_failsafe, off, off; off relays follow external drive.
// - fault_failsafe energized when healthy; fault_nonfailsafe energized only when faulted.
// - Relays show running, at_speed, alarm, ready and locked out.
// - Relays show overcurrent, undercurrent and overload alarms.
// - Shunt relay fail-safe energized unless shunt fault; non-fail-safe only on it.
// - Relays show ground fault, energy saver, heating, slow speed, fan, braking.
// - During controlled fault stop all relays but at_speed hold their state.
`timescale 1ns/100ps

module starter_io_function_mapper (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [io_map_pkg::NUM_IN-1:0] din,
    input wire io_map_pkg::in_func_t in_func [io_map_pkg::NUM_IN],
    input wire logic cfg_load,
    input wire logic [9:0] fault_input_delay,
    input wire io_map_pkg::relay_func_t relay_func [io_map_pkg::NUM_RELAY],
    input wire logic [io_map_pkg::NUM_RELAY-1:0] relay_manual,
    input wire io_map_pkg::starter_state_t starter_state,
    input wire logic overload_tripped,
    input wire logic ctrl_fault_stop,
    output io_map_pkg::input_req_t req,
    output logic input_trip,
    output logic [io_map_pkg::NUM_RELAY-1:0] relay_out
);
    import io_map_pkg::*;

    localparam int TCW = $clog2(TENTH_CYCLES);

    logic [NUM_IN-1:0] din_s1_r;
    logic [NUM_IN-1:0] din_s2_r;
    in_func_t func_r [NUM_IN];
    relay_func_t rfunc_r [NUM_RELAY];
    logic [9:0] delay_r;
    logic [TCW-1:0] tick_cnt_r;
    logic tick;
    logic [9:0] hold_cnt_r [NUM_IN];
    logic [NUM_IN-1:0] at_level;
    logic [NUM_IN-1:0] trip_hit;
    input_req_t req_nxt;
    logic [NUM_RELAY-1:0] relay_nxt;

    // Two-stage input synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            din_s1_r <= '0;
            din_s2_r <= '0;
        end else begin
            din_s1_r <= din;
            din_s2_r <= din_s1_r;
        end
    end

    // Selector and delay configuration, delay clamped to legal range
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            func_r[0] <= IN0_RST;
            func_r[1] <= IN12_RST;
            func_r[2] <= IN12_RST;
            rfunc_r[0] <= RL0_RST;
            rfunc_r[1] <= RL12_RST;
            rfunc_r[2] <= RL12_RST;
            delay_r <= DELAY_RST;
        end else if (cfg_load) begin
            func_r <= in_func;
            rfunc_r <= relay_func;
            if (fault_input_delay < DELAY_MIN) begin
                delay_r <= DELAY_MIN;
            end else if (fault_input_delay > DELAY_MAX) begin
                delay_r <= DELAY_MAX;
            end else begin
                delay_r <= fault_input_delay;
            end
        end
    end

    // Tenth-second tick divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end
    assign tick = (tick_cnt_r == TCW'(TENTH_CYCLES - 1));

    // Fault level detect per input
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            at_level[i] = ((func_r[i] == IN_FAULT_ON_HIGH) && din_s2_r[i]) ||
                          ((func_r[i] == IN_FAULT_ON_LOW) && !din_s2_r[i]);
            // One extra tick absorbs the free-running divider phase
            trip_hit[i] = at_level[i] && (hold_cnt_r[i] > delay_r);
        end
    end

    // Hold timers restart whenever the fault level is left
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_IN; i++) begin
                hold_cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (!at_level[i]) begin
                    hold_cnt_r[i] <= '0;
                end else if (tick && hold_cnt_r[i] <= delay_r) begin
                    hold_cnt_r[i] <= hold_cnt_r[i] + 10'h001;
                end
            end
        end
    end

    // Trip output
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_trip <= 1'b0;
        end else begin
            input_trip <= |trip_hit;
        end
    end

    // Function requests from the mapped inputs
    always_comb begin
        req_nxt = '0;
        req_nxt.isolator_ok = 1'b1;
        req_nxt.line_contactor_ok = 1'b1;
        req_nxt.bypass_ok = 1'b1;
        req_nxt.run_allow = 1'b1;
        for (int i = 0; i < NUM_IN; i++) begin
            case (func_r[i])
                IN_OFF: begin
                end
                IN_STOP: req_nxt.stop = req_nxt.stop | !din_s2_r[i];
                IN_FAULT_CLEAR: req_nxt.fault_clear = req_nxt.fault_clear | din_s2_r[i];
                IN_ISOLATOR_MONITOR: req_nxt.isolator_ok = din_s2_r[i];
                IN_LINE_CONTACTOR_CONFIRM: req_nxt.line_contactor_ok = din_s2_r[i];
                IN_BYPASS_CONFIRM: req_nxt.bypass_ok = din_s2_r[i];
                IN_OVERLOAD_CONTENT_CLEAR: req_nxt.overload_clear = req_nxt.overload_clear |
                    (din_s2_r[i] & overload_tripped);
                IN_SOURCE_SELECT: req_nxt.remote_source = din_s2_r[i];
                IN_HEAT_INHIBIT: req_nxt.heat_inhibit = req_nxt.heat_inhibit | din_s2_r[i];
                IN_HEAT_PERMIT: req_nxt.heat_permit = req_nxt.heat_permit | din_s2_r[i];
                IN_SECOND_RAMP_SELECT: req_nxt.second_ramp = req_nxt.second_ramp | din_s2_r[i];
                IN_SLOW_FWD: req_nxt.slow_fwd = req_nxt.slow_fwd | din_s2_r[i];
                IN_SLOW_REV: req_nxt.slow_rev = req_nxt.slow_rev | din_s2_r[i];
                IN_BRAKE_INHIBIT: req_nxt.brake_inhibit = req_nxt.brake_inhibit | din_s2_r[i];
                IN_BRAKE_PERMIT: req_nxt.brake_permit = req_nxt.brake_permit | din_s2_r[i];
                IN_RUN_PERMIT: req_nxt.run_allow = req_nxt.run_allow & din_s2_r[i];
                IN_RUN_INHIBIT: req_nxt.run_allow = req_nxt.run_allow & !din_s2_r[i];
                default: begin
                end
            endcase
        end
    end

    // Registered requests
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req <= '0;
        end else begin
            req <= req_nxt;
        end
    end

    // Relay state selection
    always_comb begin
        for (int r = 0; r < NUM_RELAY; r++) begin
            case (rfunc_r[r])
                RL_OFF: relay_nxt[r] = relay_manual[r];
                RL_FAULT_FAILSAFE: relay_nxt[r] = !starter_state.faulted;
                RL_FAULT_NONFAILSAFE: relay_nxt[r] = starter_state.faulted;
                RL_RUNNING: relay_nxt[r] = starter_state.running;
                RL_AT_SPEED: relay_nxt[r] = starter_state.at_speed;
                RL_ALARM: relay_nxt[r] = starter_state.alarm;
                RL_READY: relay_nxt[r] = starter_state.ready;
                RL_LOCKED_OUT: relay_nxt[r] = starter_state.locked_out;
                RL_OVERCURRENT: relay_nxt[r] = starter_state.overcurrent;
                RL_UNDERCURRENT: relay_nxt[r] = starter_state.undercurrent;
                RL_OL_ALARM: relay_nxt[r] = starter_state.ol_alarm;
                RL_SHUNT_FAILSAFE: relay_nxt[r] = !starter_state.shunt_trip;
                RL_SHUNT_NONFAILSAFE: relay_nxt[r] = starter_state.shunt_trip;
                RL_GROUND_FAULT: relay_nxt[r] = starter_state.ground_fault;
                RL_ENERGY_SAVER: relay_nxt[r] = starter_state.energy_saver;
                RL_HEATING: relay_nxt[r] = starter_state.heating;
                RL_SLOW_SPEED: relay_nxt[r] = starter_state.slow_speed;
                RL_SLOW_FWD: relay_nxt[r] = starter_state.slow_fwd;
                RL_SLOW_REV: relay_nxt[r] = starter_state.slow_rev;
                RL_FAN: relay_nxt[r] = starter_state.fan;
                RL_BRAKING: relay_nxt[r] = starter_state.braking;
                default: relay_nxt[r] = 1'b0;
            endcase
        end
    end

    // Relay outputs, frozen except at_speed during controlled stop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            relay_out <= '0;
        end else begin
            for (int r = 0; r < NUM_RELAY; r++) begin
                if (!ctrl_fault_stop || rfunc_r[r] == RL_AT_SPEED) begin
                    relay_out[r] <= relay_nxt[r];
                end
            end
        end
    end

    // Checks
    property p_hold_relay;
        @(posedge clk) disable iff (!rst_b)
        (ctrl_fault_stop && rfunc_r[0] != RL_AT_SPEED) |=> $stable(relay_out[0]);
    endproperty
    a_hold_relay: assert property (p_hold_relay) else $error("relay changed during controlled stop");

    property p_failsafe;
        @(posedge clk) disable iff (!rst_b)
        (!ctrl_fault_stop && rfunc_r[1] == RL_FAULT_FAILSAFE) |=> (relay_out[1] == !$past(starter_state.faulted));
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("failsafe relay wrong");

    property p_shunt_nfs;
        @(posedge clk) disable iff (!rst_b)
        (!ctrl_fault_stop && rfunc_r[0] == RL_SHUNT_NONFAILSAFE) |=> (relay_out[0] == $past(starter_state.shunt_trip));
    endproperty
    a_shunt_nfs: assert property (p_shunt_nfs) else $error("shunt relay wrong");

    property p_no_early_trip;
        @(posedge clk) disable iff (!rst_b)
        (input_trip) |-> $past(hold_cnt_r[0] > delay_r || hold_cnt_r[1] > delay_r || hold_cnt_r[2] > delay_r);
    endproperty
    a_no_early_trip: assert property (p_no_early_trip) else $error("trip before delay");

    property p_restart;
        @(posedge clk) disable iff (!rst_b)
        (!at_level[0]) |=> (hold_cnt_r[0] == 10'h000);
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    property p_off_only_fault;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] != IN_FAULT_ON_HIGH && func_r[0] != IN_FAULT_ON_LOW) |-> !at_level[0];
    endproperty
    a_off_only_fault: assert property (p_off_only_fault) else $error("delay used by other function");

    property p_source;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_SOURCE_SELECT && func_r[1] != IN_SOURCE_SELECT && func_r[2] != IN_SOURCE_SELECT)
            |=> (req.remote_source == $past(din_s2_r[0]));
    endproperty
    a_source: assert property (p_source) else $error("source select wrong");

    property p_run_inhibit;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_RUN_INHIBIT && din_s2_r[0]) |=> !req.run_allow;
    endproperty
    a_run_inhibit: assert property (p_run_inhibit) else $error("run inhibit ignored");

    property p_stop;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_STOP) |=> (req.stop || $past(din_s2_r[0]));
    endproperty
    a_stop: assert property (p_stop) else $error("stop input ignored");

    property p_fault_clear;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_FAULT_CLEAR) |=> (req.fault_clear || !$past(din_s2_r[0]));
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault clear ignored");

    property p_heat_permit;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_HEAT_PERMIT) |=> (req.heat_permit || !$past(din_s2_r[0]));
    endproperty
    a_heat_permit: assert property (p_heat_permit) else $error("heat permit ignored");

    property p_second_ramp;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_SECOND_RAMP_SELECT) |=> (req.second_ramp || !$past(din_s2_r[0]));
    endproperty
    a_second_ramp: assert property (p_second_ramp) else $error("second ramp ignored");

    property p_slow_fwd;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_SLOW_FWD) |=> (req.slow_fwd || !$past(din_s2_r[0]));
    endproperty
    a_slow_fwd: assert property (p_slow_fwd) else $error("slow forward ignored");

    property p_brake_permit;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_BRAKE_PERMIT) |=> (req.brake_permit || !$past(din_s2_r[0]));
    endproperty
    a_brake_permit: assert property (p_brake_permit) else $error("brake permit ignored");

    property p_run_permit;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_RUN_PERMIT) |=> (!req.run_allow || $past(din_s2_r[0]));
    endproperty
    a_run_permit: assert property (p_run_permit) else $error("run permit ignored");

    property p_isolator;
        @(posedge clk) disable iff (!rst_b)
        (func_r[2] == IN_ISOLATOR_MONITOR) |=> (req.isolator_ok == $past(din_s2_r[2]));
    endproperty
    a_isolator: assert property (p_isolator) else $error("isolator monitor wrong");

    property p_ol_clear;
        @(posedge clk) disable iff (!rst_b)
        (!overload_tripped) |=> !req.overload_clear;
    endproperty
    a_ol_clear: assert property (p_ol_clear) else $error("overload clear without trip");

    property p_fault_low;
        @(posedge clk) disable iff (!rst_b)
        (func_r[0] == IN_FAULT_ON_LOW) |-> (at_level[0] == !din_s2_r[0]);
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("fault low level wrong");

    property p_braking;
        @(posedge clk) disable iff (!rst_b)
        (!ctrl_fault_stop && rfunc_r[2] == RL_BRAKING) |=> (relay_out[2] == $past(starter_state.braking));
    endproperty
    a_braking: assert property (p_braking) else $error("braking relay wrong");

    property p_at_speed;
        @(posedge clk) disable iff (!rst_b)
        (rfunc_r[1] == RL_AT_SPEED) |=> (relay_out[1] == $past(starter_state.at_speed));
    endproperty
    a_at_speed: assert property (p_at_speed) else $error("at speed relay wrong");

    property p_manual;
        @(posedge clk) disable iff (!rst_b)
        (!ctrl_fault_stop && rfunc_r[0] == RL_OFF) |=> (relay_out[0] == $past(relay_manual[0]));
    endproperty
    a_manual: assert property (p_manual) else $error("manual relay wrong");

    property p_delay_range;
        @(posedge clk) disable iff (!rst_b)
        (delay_r >= DELAY_MIN) && (delay_r <= DELAY_MAX);
    endproperty
    a_delay_range: assert property (p_delay_range) else $error("trip delay out of range");

endmodule // starter_io_function_mapper

// File: sim/field_side_model.sv
`timescale 1ns/100ps

// Field contacts feeding the logic inputs, and relay coils as loads
module field_side_model (
    input wire logic clk,
    input wire logic [2:0] switch_cmd,
    input wire logic [2:0] relay_out,
    output logic [2:0] din,
    output logic [2:0] load_on
);
    // Contacts change only off the sampling edge
    always @(negedge clk) begin
        din <= switch_cmd;
    end

    // Coil is powered while the relay is energized
    assign load_on = relay_out;
endmodule // field_side_model

// File: sim/starter_io_function_mapper_tb_top.sv
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: %s", $time, msg); end end

module starter_io_function_mapper_tb_top;
    import io_map_pkg::*;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] din;
    logic [2:0] switch_cmd = 3'h0;
    logic [2:0] load_on;
    in_func_t in_func [NUM_IN];
    in_func_t dflt_in [NUM_IN];
    relay_func_t relay_func [NUM_RELAY];
    logic cfg_load = 1'b0;
    logic [9:0] fault_input_delay = 10'h001;
    logic [NUM_RELAY-1:0] relay_manual = 3'h0;
    starter_state_t starter_state = '0;
    logic overload_tripped = 1'b0;
    logic ctrl_fault_stop = 1'b0;
    input_req_t req;
    logic input_trip;
    logic [NUM_RELAY-1:0] relay_out;
    int fail_count = 0;
    int cmp_count = 0;
    logic [31:0] rnd = 32'h0F7F;

    // 25 MHz clock
    always #20 clk = ~clk;

    starter_io_function_mapper starter_io_function_mapper_inst (
        .clk(clk), .rst_b(rst_b), .din(din), .in_func(in_func), .cfg_load(cfg_load),
        .fault_input_delay(fault_input_delay), .relay_func(relay_func), .relay_manual(relay_manual),
        .starter_state(starter_state), .overload_tripped(overload_tripped),
        .ctrl_fault_stop(ctrl_fault_stop), .req(req), .input_trip(input_trip), .relay_out(relay_out)
    );

    field_side_model field_side_model_inst (
        .clk(clk), .switch_cmd(switch_cmd), .relay_out(relay_out), .din(din), .load_on(load_on)
    );

    // Random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected function requests from selectors and input levels
    function automatic input_req_t exp_req(input in_func_t f [NUM_IN], input logic [2:0] d, input logic olt);
        input_req_t r;
        r = '0;
        r.isolator_ok = 1'b1;
        r.line_contactor_ok = 1'b1;
        r.bypass_ok = 1'b1;
        r.run_allow = 1'b1;
        for (int i = 0; i < NUM_IN; i++) begin
            case (f[i])
                IN_STOP: r.stop |= !d[i];
                IN_FAULT_CLEAR: r.fault_clear |= d[i];
                IN_ISOLATOR_MONITOR: r.isolator_ok = d[i];
                IN_LINE_CONTACTOR_CONFIRM: r.line_contactor_ok = d[i];
                IN_BYPASS_CONFIRM: r.bypass_ok = d[i];
                IN_OVERLOAD_CONTENT_CLEAR: r.overload_clear |= d[i] & olt;
                IN_SOURCE_SELECT: r.remote_source = d[i];
                IN_HEAT_INHIBIT: r.heat_inhibit |= d[i];
                IN_HEAT_PERMIT: r.heat_permit |= d[i];
                IN_SECOND_RAMP_SELECT: r.second_ramp |= d[i];
                IN_SLOW_FWD: r.slow_fwd |= d[i];
                IN_SLOW_REV: r.slow_rev |= d[i];
                IN_BRAKE_INHIBIT: r.brake_inhibit |= d[i];
                IN_BRAKE_PERMIT: r.brake_permit |= d[i];
                IN_RUN_PERMIT: r.run_allow &= d[i];
                IN_RUN_INHIBIT: r.run_allow &= !d[i];
                default: ;
            endcase
        end
        return r;
    endfunction

    // Expected relay level for one selector
    function automatic logic exp_rly(input relay_func_t f, input starter_state_t s, input logic m);
        case (f)
            RL_OFF: return m;
            RL_FAULT_FAILSAFE: return !s.faulted;
            RL_FAULT_NONFAILSAFE: return s.faulted;
            RL_RUNNING: return s.running;
            RL_AT_SPEED: return s.at_speed;
            RL_ALARM: return s.alarm;
            RL_READY: return s.ready;
            RL_LOCKED_OUT: return s.locked_out;
            RL_OVERCURRENT: return s.overcurrent;
            RL_UNDERCURRENT: return s.undercurrent;
            RL_OL_ALARM: return s.ol_alarm;
            RL_SHUNT_FAILSAFE: return !s.shunt_trip;
            RL_SHUNT_NONFAILSAFE: return s.shunt_trip;
            RL_GROUND_FAULT: return s.ground_fault;
            RL_ENERGY_SAVER: return s.energy_saver;
            RL_HEATING: return s.heating;
            RL_SLOW_SPEED: return s.slow_speed;
            RL_SLOW_FWD: return s.slow_fwd;
            RL_SLOW_REV: return s.slow_rev;
            RL_FAN: return s.fan;
            RL_BRAKING: return s.braking;
            default: return 1'b0;
        endcase
    endfunction

    // Load selectors with a one-cycle strobe
    task automatic apply_cfg();
        @(negedge clk);
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
    endtask

    // Let the synchroniser and output registers settle
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask

    // Compare all outputs against the models
    task automatic check_all(input in_func_t f [NUM_IN]);
        logic [2:0] er;
        for (int i = 0; i < NUM_RELAY; i++) er[i] = exp_rly(relay_func[i], starter_state, relay_manual[i]);
        `CHK(req, exp_req(f, switch_cmd, overload_tripped), "input request mismatch")
        `CHK(relay_out, er, "relay output mismatch")
        `CHK(load_on, er, "relay load mismatch")
        `CHK(input_trip, 1'b0, "trip before delay elapsed")
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        #(40 * 8000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        // Non-default selectors present but never loaded before reset
        for (int i = 0; i < NUM_IN; i++) in_func[i] = IN_SOURCE_SELECT;
        for (int i = 0; i < NUM_RELAY; i++) relay_func[i] = RL_RUNNING;
        dflt_in = '{IN0_RST, IN12_RST, IN12_RST};
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        // Reset selectors: stop, off, off and fail-safe, off, off
        switch_cmd = 3'b110;
        relay_manual = 3'b101;
        settle();
        `CHK(req, exp_req(dflt_in, 3'b110, 1'b0), "default input mapping")
        `CHK(relay_out, 3'b101, "default relay mapping")
        starter_state.faulted = 1'b1;
        switch_cmd = 3'b111;
        settle();
        `CHK(relay_out, 3'b100, "fail-safe relay while faulted")
        `CHK(req, exp_req(dflt_in, 3'b111, 1'b0), "off inputs have no effect")
        // Every selector code swept, rest random
        for (int n = 0; n < 63; n++) begin
            for (int i = 0; i < NUM_IN; i++) begin
                rnd = lfsr_next(rnd);
                in_func[i] = in_func_t'(5'(rnd % 19));
                relay_func[i] = relay_func_t'(5'((rnd >> 8) % 21));
            end
            in_func[n % 3] = in_func_t'(5'(n % 19));
            relay_func[n % 3] = relay_func_t'(5'(n % 21));
            rnd = lfsr_next(rnd);
            switch_cmd = rnd[2:0];
            relay_manual = rnd[5:3];
            overload_tripped = rnd[6];
            fault_input_delay = rnd[13:4];
            starter_state = starter_state_t'(rnd[31:14]);
            apply_cfg();
            settle();
            check_all(in_func);
        end
        // Fault level held well short of the delay, then dropped
        in_func = '{IN_FAULT_ON_HIGH, IN_FAULT_ON_LOW, IN_OFF};
        switch_cmd = 3'b001;
        fault_input_delay = 10'h000; // Below range, clamped on load
        apply_cfg();
        repeat (300) @(negedge clk);
        `CHK(input_trip, 1'b0, "early trip on held fault level")
        switch_cmd = 3'b010;
        settle();
        `CHK(input_trip, 1'b0, "trip after fault level left")
        // Relays hold during a controlled fault stop, at-speed excepted
        relay_func = '{RL_RUNNING, RL_FAULT_FAILSAFE, RL_AT_SPEED};
        starter_state = '0;
        starter_state.at_speed = 1'b1;
        starter_state.running = 1'b1;
        apply_cfg();
        settle();
        `CHK(relay_out, 3'b111, "relays before fault stop")
        ctrl_fault_stop = 1'b1;
        starter_state = '0;
        starter_state.faulted = 1'b1;
        settle();
        `CHK(relay_out, 3'b011, "relay hold in fault stop")
        ctrl_fault_stop = 1'b0;
        settle();
        `CHK(relay_out, 3'b000, "relays after fault stop")
        report_and_stop();
    end
endmodule // starter_io_function_mapper_tb_top
